/* include/dcc_pkg.sv */
// Purpose: shared constants for the dma channel control slice
// Assumes: 8-bit special-function register access on one register page
// Notes:   offsets are the special-function addresses of that page
package dcc_pkg;
	localparam int          NUM_CHAN        = 7;
	localparam int          SIZE_W          = 16;
	localparam int          PTR_W           = 3;
	localparam int          FIFO_DEPTH      = 32;
	localparam int          FIFO_W          = 8 + PTR_W;
	localparam logic [7:0]  SFR_PAGE        = 8'h02;
	localparam logic [7:0]  ADDR_POINTER    = 8'hd1;
	localparam logic [7:0]  ADDR_ACTIVITY   = 8'hd5;
	localparam logic [7:0]  ADDR_WRAP_MODE  = 8'hd6;
	localparam logic [2:0]  PTR_INVALID     = 3'h7;
	localparam int          WRAP_BIT        = 0;
	localparam logic [2:0]  RST_POINTER     = 3'h0;
	localparam logic [6:0]  RST_ACTIVITY    = 7'h00;
	localparam logic [6:0]  RST_WRAP        = 7'h00;
	localparam logic [7:0]  RST_RDATA       = 8'h00;
endpackage : dcc_pkg

/* include/dcc_chan_if.sv */
// Purpose: control bundle between the top and one channel unit
// Assumes: one instance per channel
// Notes:   done and mid are single-cycle events from the unit
`timescale 1ns/1ps
interface dcc_chan_if;
	import dcc_pkg::*;
	logic              start;
	logic              step;
	logic              wrap;
	logic              clr;
	logic [SIZE_W-1:0] size;
	logic              busy;
	logic              done;
	logic              mid;
	logic [SIZE_W-1:0] offset;
	modport ctl  (output start, step, wrap, clr, size, input busy, done, mid, offset);
	modport unit (input start, step, wrap, clr, size, output busy, done, mid, offset);
endinterface : dcc_chan_if

/* logic/dcc_fifo.sv */
// Purpose: byte fifo between the source stream and the output stage
// Assumes: one clock, synchronous active-low reset
// Notes:   pointers carry one extra bit to tell full from empty
`timescale 1ns/1ps
module dcc_fifo
	import dcc_pkg::*;
#(
	parameter int W = FIFO_W,
	parameter int D = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_reg;
	logic [AW:0]  rp_reg;
	logic         full;
	logic         empty;

	// honest flags straight from the pointers
	assign empty     = (wp_reg == rp_reg);
	assign full      = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_reg[AW-1:0]];

	// write side
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wp_reg <= '0;
		end else if (in_valid && !full) begin
			mem[wp_reg[AW-1:0]] <= in_data;
			wp_reg              <= wp_reg + 1'b1;
		end
	end

	// read side
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rp_reg <= '0;
		end else if (out_ready && !empty) begin
			rp_reg <= rp_reg + 1'b1;
		end
	end
endmodule : dcc_fifo

/* logic/dcc_channel.sv */
// Purpose: one channel's busy state and address offset counter
// Assumes: step only arrives while busy
// Notes:   done and mid are combinational events for the flag logic
`timescale 1ns/1ps
module dcc_channel
	import dcc_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// control bundle
	dcc_chan_if.unit  ch
);
	logic              busy_reg;
	logic [SIZE_W-1:0] offset_reg;
	logic [SIZE_W-1:0] last_off;
	logic [SIZE_W-1:0] mid_off;
	logic              moving;

	assign moving   = ch.step && busy_reg;
	assign last_off = ch.size - 1'b1;
	// odd sizes round the midpoint up
	assign mid_off  = (ch.size >> 1) + {{(SIZE_W-1){1'b0}}, ch.size[0]};
	assign ch.done  = moving && (offset_reg == last_off);
	assign ch.mid   = moving && (offset_reg == mid_off);
	assign ch.busy  = busy_reg;
	assign ch.offset = offset_reg;

	// a forced start beats the completion of the same cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy_reg <= 1'b0;
		end else if (ch.start) begin
			busy_reg <= 1'b1;
		end else if (ch.done) begin
			busy_reg <= 1'b0;
		end
	end

	// offset counts up, then wraps or holds at the end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			offset_reg <= '0;
		end else if (ch.clr) begin
			offset_reg <= '0;
		end else if (ch.done) begin
			if (ch.wrap) begin
				offset_reg <= '0;
			end
		end else if (moving) begin
			offset_reg <= offset_reg + 1'b1;
		end
	end
endmodule : dcc_channel

/* logic/dcc_top.sv */
// Purpose: control slice of a seven-channel byte dma engine
// Assumes: sfr strobes come from logic on clk; size, enable, stall and
//          clear inputs come from the neighbouring configuration slice
// Notes:   lowest busy, unstalled channel owns the source stream
// How it works
// - writing one to busy bit starts channel
// - busy bit reads one while transferring
// - pointer picks channel 0-6; 111 none
// - wrap register reaches the selected channel's copy
// - offset runs from zero to size minus one
// - offset at size minus one completes, flags
// - wrap bit 0 enables wrapping, resets zero
// - wrapping returns offset to zero after completion
// - completion flag sticky until software clear
// - midpoint flag at half size, rounded up
`timescale 1ns/1ps
module dcc_top
	import dcc_pkg::*;
(
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	// special-function register access
	input  wire logic [7:0]                     sfr_page,
	input  wire logic [7:0]                     sfr_addr,
	input  wire logic                           sfr_wr,
	input  wire logic                           sfr_rd,
	input  wire logic [7:0]                     sfr_wdata,
	output logic      [7:0]                     sfr_rdata,
	// per-channel configuration from the neighbouring slice
	input  wire logic [NUM_CHAN-1:0][SIZE_W-1:0] transfer_size,
	input  wire logic [NUM_CHAN-1:0]            channel_enable_bits,
	input  wire logic [NUM_CHAN-1:0]            chan_stall,
	input  wire logic [NUM_CHAN-1:0]            offset_clr,
	input  wire logic [NUM_CHAN-1:0]            completion_clr,
	input  wire logic [NUM_CHAN-1:0]            midpoint_clr,
	// channel state
	output logic      [NUM_CHAN-1:0]            chan_active,
	output logic      [NUM_CHAN-1:0][SIZE_W-1:0] address_offset,
	output logic      [NUM_CHAN-1:0]            completion_flags,
	output logic      [NUM_CHAN-1:0]            midpoint_flags,
	// source byte stream
	input  wire logic                           src_valid,
	input  wire logic [7:0]                     src_data,
	output logic                                src_ready,
	// destination byte stream, tagged with the channel
	output logic                                dst_valid,
	output logic      [7:0]                     dst_data,
	output logic      [PTR_W-1:0]               dst_chan,
	input  wire logic                           dst_ready
);
	logic [PTR_W-1:0]    pointer_reg;
	logic [NUM_CHAN-1:0] wrap_reg;
	logic [7:0]          rdata_reg;
	logic [NUM_CHAN-1:0] en_q_reg;
	logic [NUM_CHAN-1:0] cmpl_reg;
	logic [NUM_CHAN-1:0] mid_reg;
	logic                dvalid_reg;
	logic [7:0]          ddata_reg;
	logic [PTR_W-1:0]    dchan_reg;
	logic                page_hit;
	logic                wr_act;
	logic                wr_ptr;
	logic                wr_wrap;
	logic                rd_hit;
	logic                ptr_ok;
	logic [NUM_CHAN-1:0] busy_vec;
	logic [NUM_CHAN-1:0] done_vec;
	logic [NUM_CHAN-1:0] mid_vec;
	logic [NUM_CHAN-1:0] start_vec;
	logic [NUM_CHAN-1:0] grant;
	logic [PTR_W-1:0]    grant_idx;
	logic                grant_any;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [FIFO_W-1:0]   fifo_out_data;
	logic                stage_load;
	logic                push;
	logic [7:0]          rdata_next;

	dcc_chan_if ch_if [NUM_CHAN] ();

	// address decode on the dma register page
	assign page_hit = (sfr_page == SFR_PAGE);
	assign wr_act   = sfr_wr && page_hit && (sfr_addr == ADDR_ACTIVITY);
	assign wr_ptr   = sfr_wr && page_hit && (sfr_addr == ADDR_POINTER);
	assign wr_wrap  = sfr_wr && page_hit && (sfr_addr == ADDR_WRAP_MODE);
	assign rd_hit   = sfr_rd && page_hit;
	assign ptr_ok   = (pointer_reg != PTR_INVALID);

	// per-channel units; a one written to a busy bit or a rising enable starts it
	for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
		assign start_vec[i]     = (wr_act && sfr_wdata[i])
		                          || (channel_enable_bits[i] && !en_q_reg[i]);
		assign ch_if[i].start   = start_vec[i];
		assign ch_if[i].step    = push && grant[i];
		assign ch_if[i].wrap    = wrap_reg[i];
		assign ch_if[i].clr     = offset_clr[i];
		assign ch_if[i].size    = transfer_size[i];
		assign busy_vec[i]      = ch_if[i].busy;
		assign done_vec[i]      = ch_if[i].done;
		assign mid_vec[i]       = ch_if[i].mid;
		assign address_offset[i] = ch_if[i].offset;
		dcc_channel dcc_channel_inst (
			.clk   (clk),
			.rst_b (rst_b),
			.ch    (ch_if[i])
		);
	end

	assign chan_active = busy_vec;

	// enable history for start on the rising edge of an enable bit
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			en_q_reg <= RST_ACTIVITY;
		end else begin
			en_q_reg <= channel_enable_bits;
		end
	end

	// pointer register; 111 is stored but selects no channel
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pointer_reg <= RST_POINTER;
		end else if (wr_ptr) begin
			pointer_reg <= sfr_wdata[PTR_W-1:0];
		end
	end

	// wrap bits, one per channel, reached through the pointer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wrap_reg <= RST_WRAP;
		end else if (wr_wrap && ptr_ok) begin
			wrap_reg[pointer_reg] <= sfr_wdata[WRAP_BIT];
		end
	end

	// read mux; unused and reserved bits come back as zero
	always_comb begin
		rdata_next = RST_RDATA;
		if (sfr_addr == ADDR_POINTER) begin
			rdata_next[PTR_W-1:0] = pointer_reg;
		end else if (sfr_addr == ADDR_ACTIVITY) begin
			rdata_next[NUM_CHAN-1:0] = busy_vec;
		end else if (sfr_addr == ADDR_WRAP_MODE && ptr_ok) begin
			rdata_next[WRAP_BIT] = wrap_reg[pointer_reg];
		end
	end

	// read data is registered so the port comes from a flop
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_reg <= RST_RDATA;
		end else if (rd_hit) begin
			rdata_reg <= rdata_next;
		end
	end

	assign sfr_rdata = rdata_reg;

	// completion flags; a new event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmpl_reg <= RST_ACTIVITY;
		end else begin
			cmpl_reg <= (cmpl_reg & ~completion_clr) | done_vec;
		end
	end

	// midpoint flags, same set-over-clear priority
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mid_reg <= RST_ACTIVITY;
		end else begin
			mid_reg <= (mid_reg & ~midpoint_clr) | mid_vec;
		end
	end

	assign completion_flags = cmpl_reg;
	assign midpoint_flags   = mid_reg;

	// fixed priority: lowest busy channel that is not stalled
	always_comb begin
		grant     = '0;
		grant_idx = '0;
		grant_any = 1'b0;
		for (int i = NUM_CHAN - 1; i >= 0; i--) begin
			if (busy_vec[i] && !chan_stall[i]) begin
				grant     = '0;
				grant[i]  = 1'b1;
				grant_idx = PTR_W'(i);
				grant_any = 1'b1;
			end
		end
	end

	// source only moves when a channel owns it and the fifo has room
	assign src_ready = grant_any && fifo_in_ready;
	assign push      = src_valid && src_ready;

	dcc_fifo #(
		.W (FIFO_W),
		.D (FIFO_DEPTH)
	) dcc_fifo_inst (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_data   ({grant_idx, src_data}),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (stage_load)
	);

	// output stage keeps the stream ports on flops; it stalls the fifo
	assign stage_load = !dvalid_reg || dst_ready;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dvalid_reg <= 1'b0;
			ddata_reg  <= 8'h00;
			dchan_reg  <= '0;
		end else if (stage_load) begin
			dvalid_reg <= fifo_out_valid;
			ddata_reg  <= fifo_out_data[7:0];
			dchan_reg  <= fifo_out_data[FIFO_W-1:8];
		end
	end

	assign dst_valid = dvalid_reg;
	assign dst_data  = ddata_reg;
	assign dst_chan  = dchan_reg;

	// checks kept next to the logic they guard
	a_force_start: assert property (
		@(posedge clk) disable iff (!rst_b)
		(wr_act && sfr_wdata[0]) |=> chan_active[0])
		else $error("forced start did not make channel 0 busy");

	a_zero_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		(wr_act && !sfr_wdata[0] && !chan_active[0] && !channel_enable_bits[0])
		|=> !chan_active[0])
		else $error("writing zero started channel 0");

	a_busy_read: assert property (
		@(posedge clk) disable iff (!rst_b)
		(rd_hit && sfr_addr == ADDR_ACTIVITY) |=> sfr_rdata == {1'b0, $past(busy_vec)})
		else $error("busy read does not match channel state");

	a_top_bit_zero: assert property (
		@(posedge clk) disable iff (!rst_b)
		sfr_rdata[7] == 1'b0)
		else $error("unused top bit read as one");

	a_invalid_sel: assert property (
		@(posedge clk) disable iff (!rst_b)
		(wr_wrap && pointer_reg == PTR_INVALID) |=> $stable(wrap_reg))
		else $error("pointer 111 changed a wrap bit");

	a_wrap_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		(wr_wrap && ptr_ok) |=> wrap_reg[$past(pointer_reg)] == $past(sfr_wdata[WRAP_BIT]))
		else $error("wrap write missed the selected channel");

	a_wrap_read: assert property (
		@(posedge clk) disable iff (!rst_b)
		(rd_hit && sfr_addr == ADDR_WRAP_MODE)
		|=> sfr_rdata[7:1] == 7'h00)
		else $error("reserved wrap bits read nonzero");

	a_offset_step: assert property (
		@(posedge clk) disable iff (!rst_b)
		(ch_if[0].step && chan_active[0] && !done_vec[0] && !offset_clr[0])
		|=> address_offset[0] == $past(address_offset[0]) + 16'h0001)
		else $error("offset did not advance by one");

	a_done_flag: assert property (
		@(posedge clk) disable iff (!rst_b)
		done_vec[0] |-> address_offset[0] == transfer_size[0] - 16'h0001 ##1 completion_flags[0])
		else $error("completion flag not set at last offset");

	a_flag_sticky: assert property (
		@(posedge clk) disable iff (!rst_b)
		(completion_flags[0] && !completion_clr[0]) |=> completion_flags[0])
		else $error("completion flag dropped without a clear");

	a_mid_flag: assert property (
		@(posedge clk) disable iff (!rst_b)
		mid_vec[1] |=> midpoint_flags[1])
		else $error("midpoint event lost");

	a_wrap_zero: assert property (
		@(posedge clk) disable iff (!rst_b)
		(done_vec[1] && wrap_reg[1] && !offset_clr[1]) |=> address_offset[1] == 16'h0000)
		else $error("wrap did not return offset to zero");

	a_busy_drop: assert property (
		@(posedge clk) disable iff (!rst_b)
		(done_vec[0] && !start_vec[0]) |=> !chan_active[0])
		else $error("busy stayed set after completion");
endmodule : dcc_top

/* dv/dcc_far_model.sv */
// Purpose: far-side model, a byte source feeding the block and a byte sink
// Assumes: bench changes feed_en and sink_mode just after rising edges
// Notes:   sink_mode 0 takes every cycle, 1 every other cycle, 2 never
`timescale 1ns/1ps
module dcc_far_model
	import dcc_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// bench control
	input  wire logic             feed_en,
	input  wire logic [1:0]       sink_mode,
	// source stream
	output logic                  src_valid,
	output logic      [7:0]       src_data,
	input  wire logic             src_ready,
	// destination stream
	input  wire logic             dst_valid,
	input  wire logic [7:0]       dst_data,
	input  wire logic [PTR_W-1:0] dst_chan,
	output logic                  dst_ready,
	// observations for the bench
	output logic      [15:0]      tx_count,
	output logic      [15:0]      rx_count,
	output logic      [PTR_W-1:0] rx_last_chan,
	output logic                  rx_bad
);
	logic toggle_reg;

	// idle data shows the inverse so a stale byte is never mistaken for a new one
	assign src_valid = feed_en;
	assign src_data  = feed_en ? tx_count[7:0] : ~tx_count[7:0];
	assign dst_ready = (sink_mode == 2'h0) || ((sink_mode == 2'h1) && toggle_reg);

	// count pushes; bytes are numbered so order faults show at the sink
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_count     <= 16'h0000;
			rx_count     <= 16'h0000;
			rx_last_chan <= 3'h0;
			rx_bad       <= 1'b0;
			toggle_reg   <= 1'b0;
		end else begin
			toggle_reg <= ~toggle_reg;
			if (src_valid && src_ready) begin
				tx_count <= tx_count + 16'h0001;
			end
			if (dst_valid && dst_ready) begin
				rx_count     <= rx_count + 16'h0001;
				rx_last_chan <= dst_chan;
				if (dst_data !== rx_count[7:0]) begin
					rx_bad <= 1'b1;
				end
			end
		end
	end
endmodule : dcc_far_model

/* dv/dma_channel_control_tb.sv */
// Purpose: self-checking bench for the dma channel control slice
// Assumes: far model feeds numbered bytes and drains the output stream
// Notes:   every scenario waits under a bounded count, never forever
`timescale 1ns/1ps
module dma_channel_control_tb;
	import dcc_pkg::*;
	logic                             clk, rst_b, sfr_wr, sfr_rd, feed_en;
	logic [7:0]                       sfr_page, sfr_addr, sfr_wdata, sfr_rdata;
	logic [NUM_CHAN-1:0][SIZE_W-1:0]  transfer_size, address_offset;
	logic [NUM_CHAN-1:0]              en_bits, stall, oclr, cclr, mclr;
	logic [NUM_CHAN-1:0]              chan_active, completion_flags, midpoint_flags;
	logic                             src_valid, src_ready, dst_valid, dst_ready, rx_bad;
	logic [7:0]                       src_data, dst_data;
	logic [PTR_W-1:0]                 dst_chan, rx_last_chan;
	logic [1:0]                       sink_mode;
	logic [15:0]                      tx_count, rx_count;
	int                               n_mismatch, num_checks, cycles;

	dcc_top dcc_top_inst (.clk(clk), .rst_b(rst_b), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.transfer_size(transfer_size), .channel_enable_bits(en_bits), .chan_stall(stall),
		.offset_clr(oclr), .completion_clr(cclr), .midpoint_clr(mclr),
		.chan_active(chan_active), .address_offset(address_offset),
		.completion_flags(completion_flags), .midpoint_flags(midpoint_flags),
		.src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
		.dst_valid(dst_valid), .dst_data(dst_data), .dst_chan(dst_chan),
		.dst_ready(dst_ready));

	dcc_far_model dcc_far_model_inst (.clk(clk), .rst_b(rst_b), .feed_en(feed_en),
		.sink_mode(sink_mode), .src_valid(src_valid), .src_data(src_data),
		.src_ready(src_ready), .dst_valid(dst_valid), .dst_data(dst_data),
		.dst_chan(dst_chan), .dst_ready(dst_ready), .tx_count(tx_count),
		.rx_count(rx_count), .rx_last_chan(rx_last_chan), .rx_bad(rx_bad));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard; the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	// one-cycle write strobe on the register page
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask : sfr_write

	// read data lands at the edge that takes the strobe
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask : sfr_read

	task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		sfr_read(a, v);
		check_val({8'h00, v}, {8'h00, exp});
	endtask : read_check

	// run the feed until the channel goes idle, then wait for the sink
	task automatic run_until_idle(input int ch);
		@(posedge clk);
		feed_en <= 1'b1;
		for (int k = 0; k < 300 && chan_active[ch] !== 1'b0; k++) @(posedge clk);
		@(posedge clk);
		feed_en <= 1'b0;
		for (int k = 0; k < 300 && rx_count !== tx_count; k++) @(posedge clk);
		#1;
	endtask : run_until_idle

	task automatic t_reset_and_fields();
		read_check(ADDR_POINTER, 8'h00);
		read_check(ADDR_ACTIVITY, 8'h00);
		read_check(ADDR_WRAP_MODE, 8'h00);
		sfr_write(ADDR_POINTER, 8'hff);
		read_check(ADDR_POINTER, 8'h07);
		sfr_write(ADDR_WRAP_MODE, 8'h01);
		read_check(ADDR_WRAP_MODE, 8'h00);
		sfr_write(ADDR_ACTIVITY, 8'h80);
		read_check(ADDR_ACTIVITY, 8'h00);
		read_check(8'hd0, 8'h00);
	endtask : t_reset_and_fields

	task automatic t_forced_start_no_wrap();
		sfr_write(ADDR_POINTER, 8'h00);
		sink_mode <= 2'h1;
		sfr_write(ADDR_ACTIVITY, 8'h01);
		read_check(ADDR_ACTIVITY, 8'h01);
		run_until_idle(0);
		check_val({9'h0, chan_active}, 16'h0000);
		check_val(address_offset[0], 16'h0003);
		check_val({15'h0, completion_flags[0]}, 16'h0001);
		check_val({15'h0, midpoint_flags[0]}, 16'h0001);
		check_val(tx_count, 16'h0004);
		read_check(ADDR_ACTIVITY, 8'h00);
		check_val({15'h0, completion_flags[0]}, 16'h0001);
		@(posedge clk);
		cclr <= 7'h01;
		mclr <= 7'h01;
		@(posedge clk);
		cclr <= 7'h00;
		mclr <= 7'h00;
		#1 check_val({9'h0, completion_flags}, 16'h0000);
		check_val({9'h0, midpoint_flags}, 16'h0000);
	endtask : t_forced_start_no_wrap

	task automatic t_wrap_per_channel();
		sfr_write(ADDR_POINTER, 8'h01);
		sfr_write(ADDR_WRAP_MODE, 8'hff);
		read_check(ADDR_WRAP_MODE, 8'h01);
		sfr_write(ADDR_POINTER, 8'h00);
		read_check(ADDR_WRAP_MODE, 8'h00);
		sfr_write(ADDR_POINTER, 8'h01);
		read_check(ADDR_WRAP_MODE, 8'h01);
		@(posedge clk);
		en_bits <= 7'h02;
		@(posedge clk);
		#1 check_val({15'h0, chan_active[1]}, 16'h0001);
		run_until_idle(1);
		check_val(address_offset[1], 16'h0000);
		check_val({15'h0, completion_flags[1]}, 16'h0001);
		check_val({15'h0, midpoint_flags[1]}, 16'h0001);
		check_val({15'h0, chan_active[1]}, 16'h0000);
		check_val(tx_count, 16'h0007);
		check_val({13'h0, rx_last_chan}, 16'h0001);
	endtask : t_wrap_per_channel

	// stopped sink: the fifo fills and refuses while the channel is still busy;
	// a stall first keeps the busy channel off the source stream
	task automatic t_fill_and_drain();
		@(posedge clk);
		sink_mode <= 2'h2;
		stall <= 7'h04;
		sfr_write(ADDR_ACTIVITY, 8'h04);
		@(posedge clk);
		feed_en <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check_val({15'h0, src_ready}, 16'h0000);
		check_val(tx_count, 16'h0007);
		@(posedge clk);
		stall <= 7'h00;
		repeat (60) @(posedge clk);
		#1 check_val({15'h0, src_ready}, 16'h0000);
		check_val({15'h0, chan_active[2]}, 16'h0001);
		check_val(address_offset[2], 16'h0021);
		@(posedge clk);
		sink_mode <= 2'h0;
		run_until_idle(2);
		check_val(address_offset[2], 16'h0027);
		check_val(rx_count, 16'h002f);
		check_val({15'h0, rx_bad}, 16'h0000);
		check_val({13'h0, rx_last_chan}, 16'h0002);
		// software zeroing the offset, as before a new transfer
		@(posedge clk);
		oclr <= 7'h04;
		@(posedge clk);
		oclr <= 7'h00;
		#1 check_val(address_offset[2], 16'h0000);
	endtask : t_fill_and_drain

	initial begin
		rst_b = 1'b0;
		sfr_page = SFR_PAGE;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		transfer_size = '0;
		transfer_size[0] = 16'h0004;
		transfer_size[1] = 16'h0003;
		transfer_size[2] = 16'h0028;
		en_bits = 7'h00;
		stall = 7'h00;
		oclr = 7'h00;
		cclr = 7'h00;
		mclr = 7'h00;
		feed_en = 1'b0;
		sink_mode = 2'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset_and_fields();
		t_forced_start_no_wrap();
		t_wrap_per_channel();
		t_fill_and_drain();
		tally_and_finish();
	end
endmodule : dma_channel_control_tb
